/* hw/rtc_multiplexed_bus_port.sv */
// Purpose: host port of a real-time clock on a multiplexed byte bus
// Assumes: pins arrive asynchronous; event inputs are core_clk pulses
// Notes:   tri-state bus pins are split into level, value and enable
// Summary of operation
// - bus style pin high selects strobe timing, low selects enable timing
// - address is captured when the address strobe falls
// - write data taken at data strobe fall or read/write rise
// - bus is driven only inside the read window of the chosen style
// - read ends and bus floats on the closing data strobe edge
// - unselected cycles still latch the address but access nothing
// - below the power-fail threshold chip select is forced inactive
// - rising address strobe discards the latched address
// - strobe style: read/write level gives the cycle direction
// - enable style: read/write is write enable, data strobe output enable
// - reset pin leaves time, calendar and byte store untouched
// - reset pin above power-fail clears enables, periodic and alarm flags, square wave; always floats irq; blocks bus
// - irq is low while any flag meets its enable
// - reading the flag register or reset releases irq
// - irq is open drain, floating when idle
// - square wave is a rate-selected divider tap, gated and power-fail off
// - wipe pin low in backup sets all general bytes to ones
// - oscillator runs from a control register enable field
`timescale 1ns/100ps
module rtc_multiplexed_bus_port
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rstn,
	// bus pins
	input  wire logic       busStyleSelect,
	input  wire logic [7:0] sharedAddrDataIn,
	output logic      [7:0] sharedAddrDataOut,
	output logic            sharedAddrDataOe,
	input  wire logic       addrLatchStrobe,
	input  wire logic       dataStrobe,
	input  wire logic       readWrite,
	input  wire logic       chipSelN,
	input  wire logic       resetPinN,
	// supply and wipe
	input  wire logic       belowPowerFail,
	input  wire logic       ramWipeN,
	// timekeeping side
	input  wire logic       oscTick,
	input  wire logic       updateInProgress,
	input  wire logic       alarmEvent,
	input  wire logic       updateEvent,
	input  wire logic       batteryValid,
	output logic            oscEnable,
	// outputs
	output logic            irqNOut,
	output logic            irqNOe,
	output logic            squareWaveOut
);

	// -------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------
	logic [15:0] pinSync;
	logic [7:0]  adSync;
	logic        styleSync;
	logic        asSync;
	logic        dsSync;
	logic        rwSync;
	logic        csNSync;
	logic        resetSyncN;
	logic        pfSync;
	logic        wipeSyncN;

	pin_sync #(.WIDTH(16), .RST_VAL(rtc_port_pkg::SYNC_RST)) u_sync
	(
		.core_clk (core_clk),
		.rstn     (rstn),
		.pinIn    ({sharedAddrDataIn, busStyleSelect, addrLatchStrobe, dataStrobe,
		            readWrite, chipSelN, resetPinN, belowPowerFail, ramWipeN}),
		.pinSync  (pinSync)
	);

	assign adSync     = pinSync[15:8];
	assign styleSync  = pinSync[7];
	assign asSync     = pinSync[6];
	assign dsSync     = pinSync[5];
	assign rwSync     = pinSync[4];
	assign csNSync    = pinSync[3];
	assign resetSyncN = pinSync[2];
	assign pfSync     = pinSync[1];
	assign wipeSyncN  = pinSync[0];

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	rtc_port_pkg::bus_state_t state_ff;
	rtc_port_pkg::bus_state_t nxt_state;
	logic [6:0]  addr_ff;
	logic [6:0]  nxt_addr;
	logic        asPrev_ff;
	logic        dsPrev_ff;
	logic        rwPrev_ff;
	logic [6:0]  regA_ff;
	logic [6:0]  nxt_regA;
	logic [7:0]  regB_ff;
	logic [7:0]  nxt_regB;
	logic        perFlag_ff;
	logic        nxt_perFlag;
	logic        almFlag_ff;
	logic        nxt_almFlag;
	logic        updFlag_ff;
	logic        nxt_updFlag;
	logic [14:0] div_ff;
	logic [14:0] nxt_div;
	logic        tapPrev_ff;
	logic        sqw_ff;
	logic        nxt_sqw;
	logic [6:0]  wipeAddr_ff;
	logic [6:0]  nxt_wipeAddr;
	logic [7:0]  rdData_ff;
	logic [7:0]  nxt_rdData;
	logic [7:0]  ramRdData;

	// -------------------------------------------------------------
	// decode
	// -------------------------------------------------------------
	logic       csActive;
	logic       asFall;
	logic       asRise;
	logic       wrStrobe;
	logic       readWin;
	logic       busWrite;
	logic       clearFlags;
	logic       irqSummary;
	logic       tapNow;
	logic       periodicRise;
	logic       wipeActive;
	logic       ramWe;
	logic [6:0] ramWrAddr;
	logic [7:0] ramWrData;

	function automatic logic isCtrlAddr(input logic [6:0] a);
		return (a >= rtc_port_pkg::ADDR_REG_A) && (a <= rtc_port_pkg::ADDR_REG_D);
	endfunction

	function automatic logic tapBit(input logic [3:0] rate, input logic [14:0] div);
		logic [3:0] idx;
		idx = (rate < 4'h3) ? rate + 4'h5 : rate - 4'h2;
		return (rate == 4'h0) ? 1'b0 : div[idx];
	endfunction

	assign csActive   = !csNSync && !pfSync && resetSyncN;
	assign asFall     = asPrev_ff && !asSync;
	assign asRise     = !asPrev_ff && asSync;
	assign wrStrobe   = styleSync ? (dsPrev_ff && !dsSync && !rwSync)
	                              : (!rwPrev_ff && rwSync);
	assign readWin    = styleSync ? (dsSync && rwSync) : (!dsSync && rwSync);
	assign busWrite   = wrStrobe && csActive && (state_ff == rtc_port_pkg::BUS_ADDR);
	assign clearFlags = (state_ff == rtc_port_pkg::BUS_READ) && !(readWin && csActive)
	                    && (addr_ff == rtc_port_pkg::ADDR_REG_C);
	assign irqSummary = (perFlag_ff && regB_ff[rtc_port_pkg::B_PIE])
	                    || (almFlag_ff && regB_ff[rtc_port_pkg::B_AIE])
	                    || (updFlag_ff && regB_ff[rtc_port_pkg::B_UIE]);
	assign oscEnable  = (regA_ff[6:4] == rtc_port_pkg::DV_OSC_RUN);
	assign tapNow       = tapBit(regA_ff[3:0], div_ff);
	assign periodicRise = tapNow && !tapPrev_ff;
	assign wipeActive   = pfSync && !wipeSyncN;

	// -------------------------------------------------------------
	// bus sequencing
	// -------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		nxt_addr  = addr_ff;
		case (state_ff)
			rtc_port_pkg::BUS_IDLE:
			begin
				if (asFall)
				begin
					nxt_state = rtc_port_pkg::BUS_ADDR;
					nxt_addr  = adSync[6:0];
				end
			end
			rtc_port_pkg::BUS_ADDR:
			begin
				if (asRise)
					nxt_state = rtc_port_pkg::BUS_IDLE;
				else if (readWin)
					nxt_state = csActive ? rtc_port_pkg::BUS_READ
					                     : rtc_port_pkg::BUS_IDLE;
				else if (wrStrobe && !csActive)
					nxt_state = rtc_port_pkg::BUS_IDLE;
			end
			rtc_port_pkg::BUS_READ:
			begin
				if (asRise)
					nxt_state = rtc_port_pkg::BUS_IDLE;
				else if (!(readWin && csActive))
					nxt_state = rtc_port_pkg::BUS_ADDR;
			end
			default:
				nxt_state = rtc_port_pkg::BUS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_ff  <= rtc_port_pkg::BUS_IDLE;
			addr_ff   <= 7'h00;
			asPrev_ff <= 1'b0;
			dsPrev_ff <= 1'b0;
			rwPrev_ff <= 1'b1;
		end
		else
		begin
			state_ff  <= nxt_state;
			addr_ff   <= nxt_addr;
			asPrev_ff <= asSync;
			dsPrev_ff <= dsSync;
			rwPrev_ff <= rwSync;
		end
	end

	// -------------------------------------------------------------
	// control registers and flags
	// -------------------------------------------------------------
	always_comb
	begin
		nxt_regA    = regA_ff;
		nxt_regB    = regB_ff;
		nxt_perFlag = periodicRise || (perFlag_ff && !clearFlags);
		nxt_almFlag = alarmEvent || (almFlag_ff && !clearFlags);
		nxt_updFlag = updateEvent || (updFlag_ff && !clearFlags);
		if (busWrite && (addr_ff == rtc_port_pkg::ADDR_REG_A))
			nxt_regA = adSync[6:0];
		if (busWrite && (addr_ff == rtc_port_pkg::ADDR_REG_B))
			nxt_regB = adSync;
		if (!resetSyncN && !pfSync)
		begin
			nxt_regB[rtc_port_pkg::B_PIE]  = 1'b0;
			nxt_regB[rtc_port_pkg::B_AIE]  = 1'b0;
			nxt_regB[rtc_port_pkg::B_UIE]  = 1'b0;
			nxt_regB[rtc_port_pkg::B_SQUARE_OUT_ENABLE] = 1'b0;
			nxt_perFlag = 1'b0;
			nxt_almFlag = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			regA_ff    <= rtc_port_pkg::REG_A_RST;
			regB_ff    <= rtc_port_pkg::REG_B_RST;
			perFlag_ff <= 1'b0;
			almFlag_ff <= 1'b0;
			updFlag_ff <= 1'b0;
		end
		else
		begin
			regA_ff    <= nxt_regA;
			regB_ff    <= nxt_regB;
			perFlag_ff <= nxt_perFlag;
			almFlag_ff <= nxt_almFlag;
			updFlag_ff <= nxt_updFlag;
		end
	end

	// -------------------------------------------------------------
	// divider, square wave, wipe walker, read data
	// -------------------------------------------------------------
	always_comb
	begin
		nxt_div      = (oscEnable && oscTick) ? div_ff + 15'h0001 : div_ff;
		nxt_sqw      = regB_ff[rtc_port_pkg::B_SQUARE_OUT_ENABLE] && !pfSync && tapNow;
		nxt_wipeAddr = wipeAddr_ff;
		if (wipeActive)
			nxt_wipeAddr = (wipeAddr_ff >= rtc_port_pkg::ADDR_RAM_LAST)
			               ? rtc_port_pkg::ADDR_RAM_FIRST : wipeAddr_ff + 7'h01;
		case (addr_ff)
			rtc_port_pkg::ADDR_REG_A: nxt_rdData = {updateInProgress, regA_ff};
			rtc_port_pkg::ADDR_REG_B: nxt_rdData = regB_ff;
			rtc_port_pkg::ADDR_REG_C: nxt_rdData = {irqSummary, perFlag_ff, almFlag_ff,
			                                       updFlag_ff, 4'h0};
			rtc_port_pkg::ADDR_REG_D: nxt_rdData = {batteryValid, 7'h00};
			default:                  nxt_rdData = ramRdData;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_ff      <= 15'h0000;
			tapPrev_ff  <= 1'b0;
			sqw_ff      <= 1'b0;
			wipeAddr_ff <= rtc_port_pkg::ADDR_RAM_FIRST;
			rdData_ff   <= 8'h00;
		end
		else
		begin
			div_ff      <= nxt_div;
			tapPrev_ff  <= tapNow;
			sqw_ff      <= nxt_sqw;
			wipeAddr_ff <= nxt_wipeAddr;
			rdData_ff   <= nxt_rdData;
		end
	end

	// -------------------------------------------------------------
	// byte store and pins
	// -------------------------------------------------------------
	assign ramWe     = wipeActive || (busWrite && !isCtrlAddr(addr_ff));
	assign ramWrAddr = wipeActive ? wipeAddr_ff : addr_ff;
	assign ramWrData = wipeActive ? rtc_port_pkg::WIPE_DATA : adSync;

	byte_store #(.ADDR_W(7), .DATA_W(8)) u_store
	(
		.core_clk  (core_clk),
		.wrEn      (ramWe),
		.wrAddr    (ramWrAddr),
		.wrData    (ramWrData),
		.rdAddr    (addr_ff),
		.rdData_ff (ramRdData)
	);

	assign sharedAddrDataOut = rdData_ff;
	assign sharedAddrDataOe  = (state_ff == rtc_port_pkg::BUS_READ);
	assign irqNOut           = 1'b0;
	assign irqNOe            = irqSummary && resetSyncN;
	assign squareWaveOut     = sqw_ff;

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence s_addr_held;
		(state_ff == rtc_port_pkg::BUS_ADDR) && !asRise;
	endsequence
	sequence s_read_close;
		(state_ff == rtc_port_pkg::BUS_READ) && !asRise && !(readWin && csActive);
	endsequence

	property p_style_read;
		s_addr_held and (styleSync ? dsSync && rwSync : !dsSync && rwSync) && csActive
		|=> sharedAddrDataOe;
	endproperty
	a_style_read: assert property (p_style_read) else $error("read window not driven");
	property p_addr_capture;
		(state_ff == rtc_port_pkg::BUS_IDLE) && asFall
		|=> (state_ff == rtc_port_pkg::BUS_ADDR) && (addr_ff == $past(adSync[6:0]));
	endproperty
	a_addr_capture: assert property (p_addr_capture) else $error("address not latched");
	property p_write_b;
		busWrite && (addr_ff == rtc_port_pkg::ADDR_REG_B) && resetSyncN
		|=> regB_ff == $past(adSync);
	endproperty
	a_write_b: assert property (p_write_b) else $error("write data lost");
	property p_read_end;
		s_read_close |=> !sharedAddrDataOe ##1 !sharedAddrDataOe || readWin;
	endproperty
	a_read_end: assert property (p_read_end) else $error("bus not floated");
	property p_no_select;
		!csActive |=> !sharedAddrDataOe && !(ramWe && !wipeActive);
	endproperty
	a_no_select: assert property (p_no_select) else $error("unselected access");
	property p_addr_clear;
		asRise |=> state_ff == rtc_port_pkg::BUS_IDLE;
	endproperty
	a_addr_clear: assert property (p_addr_clear) else $error("address kept");
	property p_reset_pin;
		!resetSyncN && !pfSync |=> !irqNOe && !regB_ff[rtc_port_pkg::B_SQUARE_OUT_ENABLE]
		&& !perFlag_ff && !almFlag_ff ##1 !squareWaveOut || resetSyncN;
	endproperty
	a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");
	property p_irq_hold;
		((perFlag_ff && regB_ff[rtc_port_pkg::B_PIE])
		 || (almFlag_ff && regB_ff[rtc_port_pkg::B_AIE])
		 || (updFlag_ff && regB_ff[rtc_port_pkg::B_UIE])) && resetSyncN
		|-> irqNOe && !irqNOut;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq not asserted");
	property p_irq_release;
		s_read_close and (addr_ff == rtc_port_pkg::ADDR_REG_C) && !periodicRise
		&& !alarmEvent && !updateEvent |=> !irqNOe;
	endproperty
	a_irq_release: assert property (p_irq_release) else $error("irq not released");
	property p_sqw_gate;
		!regB_ff[rtc_port_pkg::B_SQUARE_OUT_ENABLE] || pfSync |=> !squareWaveOut;
	endproperty
	a_sqw_gate: assert property (p_sqw_gate) else $error("square wave not gated");
	property p_wipe;
		wipeActive |-> ramWe && (ramWrData == rtc_port_pkg::WIPE_DATA)
		&& (ramWrAddr >= rtc_port_pkg::ADDR_RAM_FIRST);
	endproperty
	a_wipe: assert property (p_wipe) else $error("wipe touched clock bytes");
	property p_osc_stop;
		!oscEnable |=> $stable(div_ff);
	endproperty
	a_osc_stop: assert property (p_osc_stop) else $error("divider ran while stopped");

endmodule

/* hw/rtc_port_pkg.sv */
// Purpose: shared constants and types of the multiplexed bus port
// Assumes: 7-bit byte address space, 8-bit data
// Notes:   control registers sit in the core; everything else is byte store
package rtc_port_pkg;

	// -------------------------------------------------------------
	// address map
	// -------------------------------------------------------------
	localparam logic [6:0] ADDR_REG_A     = 7'h0A;
	localparam logic [6:0] ADDR_REG_B     = 7'h0B;
	localparam logic [6:0] ADDR_REG_C     = 7'h0C;
	localparam logic [6:0] ADDR_REG_D     = 7'h0D;
	localparam logic [6:0] ADDR_RAM_FIRST = 7'h0E;
	localparam logic [6:0] ADDR_RAM_LAST  = 7'h7F;

	// -------------------------------------------------------------
	// field positions
	// -------------------------------------------------------------
	localparam int A_BUSY     = 7;
	localparam int A_DV_LSB   = 4;
	localparam int B_PIE      = 6;
	localparam int B_AIE      = 5;
	localparam int B_UIE      = 4;
	localparam int B_SQUARE_OUT_ENABLE     = 3;
	localparam int DIV_STAGES = 15;

	// -------------------------------------------------------------
	// values after reset and fixed codes
	// -------------------------------------------------------------
	localparam logic [6:0]  REG_A_RST  = 7'h20;
	localparam logic [7:0]  REG_B_RST  = 8'h00;
	localparam logic [2:0]  DV_OSC_RUN = 3'h2;
	localparam logic [7:0]  WIPE_DATA  = 8'hFF;
	localparam logic [15:0] SYNC_RST   = 16'h001D;

	typedef enum logic [1:0]
	{
		BUS_IDLE = 2'b00,
		BUS_ADDR = 2'b01,
		BUS_READ = 2'b11
	} bus_state_t;

endpackage

/* hw/pin_sync.sv */
// Purpose: two-stage synchroniser for a group of pin levels
// Assumes: pins are levels, not pulses
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module pin_sync
#(
	parameter int              WIDTH   = 16,
	parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rstn,
	// levels
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinSync
);

	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stage1_ff <= RST_VAL;
			stage2_ff <= RST_VAL;
		end
		else
		begin
			stage1_ff <= pinIn;
			stage2_ff <= stage1_ff;
		end
	end

	assign pinSync = stage2_ff;

endmodule

/* hw/byte_store.sv */
// Purpose: byte-wide store for time bytes and general-purpose bytes
// Assumes: one write port, one registered read port
// Notes:   contents have no reset, as in a battery-backed array
`timescale 1ns/100ps
module byte_store
#(
	parameter int ADDR_W = 7,
	parameter int DATA_W = 8
)
(
	// clock
	input  wire logic              core_clk,
	// write port
	input  wire logic              wrEn,
	input  wire logic [ADDR_W-1:0] wrAddr,
	input  wire logic [DATA_W-1:0] wrData,
	// read port
	input  wire logic [ADDR_W-1:0] rdAddr,
	output logic      [DATA_W-1:0] rdData_ff
);

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	always_ff @(posedge core_clk)
	begin
		if (wrEn)
		begin
			mem[wrAddr] <= wrData;
		end
		rdData_ff <= mem[rdAddr];
	end

endmodule

/* verification/host_bus_model.sv */
// Purpose: host bus controller on the multiplexed address/data port
// Assumes: pins change at falling clock edges, each level held at least one step
// Notes:   a step of 6 cycles covers the synchroniser latency of the port
`timescale 1ns/100ps
module host_bus_model
(
	// clock
	input  wire logic       core_clk,
	// style and observed bus
	input  wire logic       busStyle,
	input  wire logic [7:0] busWire,
	input  wire logic       devOe,
	// host-driven pins
	output logic      [7:0] hostData,
	output logic            hostOe,
	output logic            addrLatchStrobe,
	output logic            dataStrobe,
	output logic            readWrite,
	output logic            chipSelN
);
	// ------------------------------------------------------------
	// pin sequencing
	// ------------------------------------------------------------
	initial
	begin
		hostData        = 8'h00;
		hostOe          = 1'b0;
		addrLatchStrobe = 1'b0;
		dataStrobe      = 1'b0;
		readWrite       = 1'b1;
		chipSelN        = 1'b1;
	end

	task automatic step();
		repeat (6) @(negedge core_clk);
	endtask

	task automatic access(input logic wr, input logic sel, input logic [7:0] addr,
		input logic [7:0] wdata, output logic [7:0] rdata, output logic oeSeen);
		rdata           = 8'h00;
		oeSeen          = 1'b0;
		dataStrobe      = !busStyle;
		chipSelN        = !sel;
		hostOe          = 1'b1;
		hostData        = addr;
		addrLatchStrobe = 1'b1;
		step();
		addrLatchStrobe = 1'b0;
		step();
		hostOe          = wr;
		hostData        = wdata;
		if (busStyle)
		begin
			readWrite = !wr;
			step();
			dataStrobe = 1'b1;
			step();
			rdata      = busWire;
			oeSeen     = devOe;
			dataStrobe = 1'b0;
		end
		else if (wr)
		begin
			readWrite = 1'b0;
			step();
			readWrite = 1'b1;
		end
		else
		begin
			dataStrobe = 1'b0;
			step();
			rdata      = busWire;
			oeSeen     = devOe;
			dataStrobe = 1'b1;
		end
		step();
		readWrite       = 1'b1;
		hostOe          = 1'b0;
		chipSelN        = 1'b1;
		addrLatchStrobe = 1'b1;
		step();
	endtask
endmodule

/* verification/tb_rtc_multiplexed_bus_port.sv */
// Purpose: self-checking bench of the multiplexed bus port
// Assumes: host model sequences the bus, bench drives the rest at falling edges
// Notes:   reset pin is never used at power-up here, so no long hold
`timescale 1ns/100ps
module tb_rtc_multiplexed_bus_port;
	logic       core_clk;
	logic       rstn;
	logic       busStyle;
	logic [7:0] hostData;
	logic       hostOe;
	logic       addrStb;
	logic       dataStb;
	logic       rdWr;
	logic       csN;
	logic       resetPinN;
	logic       belowPowerFail;
	logic       ramWipeN;
	logic       oscTick;
	logic       uip;
	logic       alarmEvent;
	logic       updateEvent;
	logic       batteryValid;
	logic [7:0] devOut;
	logic       devOe;
	logic       oscEnable;
	logic       irqNOut;
	logic       irqNOe;
	logic       squareWaveOut;
	logic [7:0] busWire;
	logic [7:0] lastWire;
	logic [7:0] rd;
	logic       oe;
	logic       lastSq;
	int         err_count;
	int         checked;
	int         cycles;

	// ------------------------------------------------------------
	// clock, bus wire and instances
	// ------------------------------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// released bus shows the inverse of its last level
	assign busWire = devOe ? devOut : (hostOe ? hostData : ~lastWire);
	always @(posedge core_clk) lastWire <= busWire;

	rtc_multiplexed_bus_port dut
	(
		.core_clk          (core_clk),
		.rstn              (rstn),
		.busStyleSelect    (busStyle),
		.sharedAddrDataIn  (busWire),
		.sharedAddrDataOut (devOut),
		.sharedAddrDataOe  (devOe),
		.addrLatchStrobe   (addrStb),
		.dataStrobe        (dataStb),
		.readWrite         (rdWr),
		.chipSelN          (csN),
		.resetPinN         (resetPinN),
		.belowPowerFail    (belowPowerFail),
		.ramWipeN          (ramWipeN),
		.oscTick           (oscTick),
		.updateInProgress  (uip),
		.alarmEvent        (alarmEvent),
		.updateEvent       (updateEvent),
		.batteryValid      (batteryValid),
		.oscEnable         (oscEnable),
		.irqNOut           (irqNOut),
		.irqNOe            (irqNOe),
		.squareWaveOut     (squareWaveOut)
	);

	host_bus_model u_host
	(
		.core_clk        (core_clk),
		.busStyle        (busStyle),
		.busWire         (busWire),
		.devOe           (devOe),
		.hostData        (hostData),
		.hostOe          (hostOe),
		.addrLatchStrobe (addrStb),
		.dataStrobe      (dataStb),
		.readWrite       (rdWr),
		.chipSelN        (csN)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks=%0d errors=%0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic sel);
		u_host.access(1'b1, sel, a, d, rd, oe);
	endtask

	task automatic rdb(input logic [7:0] a, input logic sel);
		u_host.access(1'b0, sel, a, 8'h00, rd, oe);
	endtask

	task automatic pulse_alarm();
		@(negedge core_clk);
		alarmEvent = 1'b1;
		@(negedge core_clk);
		alarmEvent = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check(irqNOe, 1'b0);
		check(squareWaveOut, 1'b0);
		check(oscEnable, 1'b1);
	endtask

	task automatic t_strobe();
		busStyle = 1'b1;
		wr(8'h20, 8'hA5, 1'b1);
		rdb(8'h20, 1'b1);
		check(rd, 8'hA5);
		check(oe, 1'b1);
		check(devOe, 1'b0);
		rdb(8'h0A, 1'b1);
		check(rd, 8'h20);
		uip = 1'b1;
		rdb(8'h0A, 1'b1);
		check(rd, 8'hA0);
		uip = 1'b0;
		rdb(8'h0D, 1'b1);
		check(rd, 8'h80);
	endtask

	task automatic t_enable();
		busStyle = 1'b0;
		wr(8'h21, 8'h3C, 1'b1);
		rdb(8'h21, 1'b1);
		check(rd, 8'h3C);
		check(oe, 1'b1);
		check(devOe, 1'b0);
		rdb(8'h20, 1'b1);
		check(rd, 8'hA5);
	endtask

	task automatic t_unsel();
		wr(8'h20, 8'h5A, 1'b0);
		rdb(8'h20, 1'b0);
		check(oe, 1'b0);
		rdb(8'h20, 1'b1);
		check(rd, 8'hA5);
	endtask

	task automatic t_power();
		belowPowerFail = 1'b1;
		wr(8'h20, 8'h11, 1'b1);
		rdb(8'h20, 1'b1);
		check(oe, 1'b0);
		belowPowerFail = 1'b0;
		rdb(8'h20, 1'b1);
		check(rd, 8'hA5);
	endtask

	task automatic t_irq();
		busStyle = 1'b1;
		wr(8'h0B, 8'h20, 1'b1);
		pulse_alarm();
		check(irqNOe, 1'b1);
		check(irqNOut, 1'b0);
		rdb(8'h0C, 1'b1);
		check(rd, 8'hA0);
		check(irqNOe, 1'b0);
		pulse_alarm();
		check(irqNOe, 1'b1);
		resetPinN = 1'b0;
		rdb(8'h0B, 1'b1);
		check(oe, 1'b0);
		check(irqNOe, 1'b0);
		resetPinN = 1'b1;
		rdb(8'h0B, 1'b1);
		check(rd, 8'h00);
		@(negedge core_clk);
		updateEvent = 1'b1;
		@(negedge core_clk);
		updateEvent = 1'b0;
		rdb(8'h0C, 1'b1);
		check(rd, 8'h10);
		rdb(8'h0C, 1'b1);
		check(rd, 8'h00);
		rdb(8'h21, 1'b1);
		check(rd, 8'h3C);
	endtask

	task automatic t_square();
		int edges;
		edges = 0;
		wr(8'h0B, 8'h08, 1'b1);
		wr(8'h0A, 8'h23, 1'b1);
		repeat (400)
		begin
			@(negedge core_clk);
			oscTick = ~oscTick;
			if (squareWaveOut !== lastSq)
				edges++;
			lastSq = squareWaveOut;
		end
		oscTick = 1'b0;
		check(8'(edges > 2), 8'h01);
		wr(8'h0A, 8'h03, 1'b1);
		check(oscEnable, 1'b0);
		wr(8'h0A, 8'h20, 1'b1);
		check(oscEnable, 1'b1);
	endtask

	task automatic t_wipe();
		belowPowerFail = 1'b1;
		ramWipeN       = 1'b0;
		repeat (300) @(negedge core_clk);
		ramWipeN       = 1'b1;
		belowPowerFail = 1'b0;
		rdb(8'h21, 1'b1);
		check(rd, 8'hFF);
		rdb(8'h7F, 1'b1);
		check(rd, 8'hFF);
		rdb(8'h0B, 1'b1);
		check(rd, 8'h08);
	endtask

	// ------------------------------------------------------------
	// main sequence and timeout
	// ------------------------------------------------------------
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			end_sim();
		end
	end

	initial
	begin
		rstn           = 1'b0;
		busStyle       = 1'b1;
		resetPinN      = 1'b1;
		belowPowerFail = 1'b0;
		ramWipeN       = 1'b1;
		oscTick        = 1'b0;
		uip            = 1'b0;
		alarmEvent     = 1'b0;
		updateEvent    = 1'b0;
		batteryValid   = 1'b1;
		lastSq         = 1'b0;
		err_count      = 0;
		checked        = 0;
		cycles         = 0;
		repeat (16) @(negedge core_clk);
		rstn = 1'b1;
		repeat (4) @(negedge core_clk);
		t_reset();
		t_strobe();
		t_enable();
		t_unsel();
		t_power();
		t_irq();
		t_square();
		t_wipe();
		end_sim();
	end
endmodule
